// ### rtl/status_service_pkg.sv
// Constants for the status and service request control block
// ==========================================================
package status_service_pkg;
   // Status byte bit positions
   localparam int BIT_USER  = 0;
   localparam int BIT_DEV   = 2;
   localparam int BIT_QUES  = 3;
   localparam int BIT_MAV   = 4;
   localparam int BIT_ESB   = 5;
   localparam int BIT_RQS   = 6;
   localparam int BIT_OPER  = 7;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] STB_RESET  = 8'h00;
   // Commands
   typedef enum logic [3:0] {
      CMD_NONE, CMD_RST, CMD_CLS, CMD_SRE, CMD_PSC, CMD_TRG, CMD_TST,
      CMD_WAI, CMD_ABORT, CMD_INIT, CMD_SEQ, CMD_OVL, CMD_CONT, CMD_POWERUP
   } cmd_t;
   typedef enum {ST_IDLE, ST_SEQ, ST_WAIT, ST_TEST} ctl_state_t;
endpackage : status_service_pkg

// ### rtl/status_service_ctrl.sv
// Command interpreter for status byte, service request and measurement control
`timescale 1ns/1ps
module status_service_ctrl (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   // Command port
   input  wire logic       cmd_valid,
   input  wire status_service_pkg::cmd_t cmd_code,
   input  wire logic [7:0] cmd_arg,
   output logic            cmd_ready,
   // Summary inputs from lower status sets, output queue state and serial poll request
   input  wire logic       user_summary,
   input  wire logic       dev_summary,
   input  wire logic       ques_summary,
   input  wire logic       esr_summary,
   input  wire logic       oper_summary,
   input  wire logic       outq_not_empty,
   input  wire logic       serial_poll,
   // Measurement side
   input  wire logic       trig_src_bus,
   input  wire logic       waiting_trigger,
   input  wire logic       seq_done,
   input  wire logic       ovl_done,
   input  wire logic       cal_done,
   input  wire logic       cal_pass,
   // Outputs
   output logic [7:0]      mask_out,
   output logic [7:0]      stb_out,
   output logic            srq_out,
   output logic            psc_out,
   output logic            trig_pulse,
   output logic            cal_start,
   output logic            tst_result,
   output logic            tst_valid,
   output logic            meas_start,
   output logic            meas_abort,
   output logic            auto_cal,
   output logic            cont_init,
   output logic            measuring_bit,
   output logic            averaging_bit,
   output logic            no_pending_operations_flag,
   output logic            opc_pending
);
   // ==========================================================
   // Registers
   logic [7:0] mask_reg, mask_next;
   logic [7:0] saved_mask_reg;
   logic       psc_reg;
   logic [7:0] stb_reg;
   logic [7:0] prev_live_reg;
   logic [7:0] prev_mask_reg;
   logic       srq_reg;
   status_service_pkg::ctl_state_t state_reg, state_next;
   logic       ovl_busy_reg;

   // ==========================================================
   // Decode
   wire take = clk_en && cmd_valid && cmd_ready;
   function automatic logic is_cmd(input logic                     t,
                                   input status_service_pkg::cmd_t code,
                                   input status_service_pkg::cmd_t c);
      is_cmd = t && (code == c);
   endfunction : is_cmd
   wire do_rst   = is_cmd(take, cmd_code, status_service_pkg::CMD_RST);
   wire do_cls   = is_cmd(take, cmd_code, status_service_pkg::CMD_CLS);
   wire do_sre   = is_cmd(take, cmd_code, status_service_pkg::CMD_SRE);
   wire do_psc   = is_cmd(take, cmd_code, status_service_pkg::CMD_PSC);
   wire do_trg   = is_cmd(take, cmd_code, status_service_pkg::CMD_TRG);
   wire do_tst   = is_cmd(take, cmd_code, status_service_pkg::CMD_TST);
   wire do_wai   = is_cmd(take, cmd_code, status_service_pkg::CMD_WAI);
   wire do_abort = is_cmd(take, cmd_code, status_service_pkg::CMD_ABORT);
   wire do_init  = is_cmd(take, cmd_code, status_service_pkg::CMD_INIT);
   wire do_seq   = is_cmd(take, cmd_code, status_service_pkg::CMD_SEQ);
   wire do_ovl   = is_cmd(take, cmd_code, status_service_pkg::CMD_OVL);
   wire do_cont  = is_cmd(take, cmd_code, status_service_pkg::CMD_CONT);
   wire do_pwr   = is_cmd(take, cmd_code, status_service_pkg::CMD_POWERUP);

   // Live status byte without bit 6
   wire [7:0] live_base = {oper_summary, 1'b0, esr_summary, outq_not_empty,
                           ques_summary, dev_summary, 1'b0, user_summary};
   wire [7:0] eff_mask  = mask_reg & 8'hbf;
   wire       mss       = |(live_base & eff_mask);
   wire [7:0] live_stb  = {live_base[7], mss, live_base[5:0]};
   wire [7:0] rise_stb  = live_base & ~prev_live_reg & eff_mask;
   wire [7:0] rise_mask = eff_mask & ~prev_mask_reg & live_base;
   wire       srq_event = |rise_stb || |rise_mask;

   // Mask next value: write, power-up restore, or hold
   wire [7:0] sre_value = cmd_arg & ~(8'h01 << status_service_pkg::BIT_RQS);
   assign mask_next = do_pwr ? (psc_reg ? status_service_pkg::MASK_RESET
                                        : saved_mask_reg)
                    : do_sre ? sre_value : mask_reg;

   // ==========================================================
   // Retained storage, never reset
   always_ff @(posedge clk) begin
      if (clk_en && do_sre) saved_mask_reg <= sre_value;
      if (clk_en && do_psc) psc_reg <= (cmd_arg != 8'h00);
   end

   // ==========================================================
   // Mask, kept by device reset
   always_ff @(posedge clk) begin
      if (sys_rst) mask_reg <= status_service_pkg::MASK_RESET;
      else if (clk_en) mask_reg <= mask_next;
   end

   // ==========================================================
   // Status byte and service request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stb_reg       <= status_service_pkg::STB_RESET;
         prev_live_reg <= 8'h00;
         prev_mask_reg <= 8'h00;
         srq_reg       <= 1'b0;
      end else if (clk_en) begin
         prev_live_reg <= live_base;
         prev_mask_reg <= eff_mask;
         // Query returns MSS; poll returns RQS
         stb_reg <= serial_poll ? {live_stb[7], srq_reg, live_stb[5:0]} : live_stb;
         if (do_cls) srq_reg <= 1'b0;
         if (srq_event) srq_reg <= 1'b1;
         else if (serial_poll) srq_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Command sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         status_service_pkg::ST_IDLE: begin
            if (do_seq) state_next = status_service_pkg::ST_SEQ;
            else if (do_wai) state_next = status_service_pkg::ST_WAIT;
            else if (do_tst) state_next = status_service_pkg::ST_TEST;
         end
         status_service_pkg::ST_SEQ:
            if (seq_done) state_next = status_service_pkg::ST_IDLE;
         status_service_pkg::ST_WAIT:
            if (!ovl_busy_reg || ovl_done) state_next = status_service_pkg::ST_IDLE;
         status_service_pkg::ST_TEST:
            if (cal_done) state_next = status_service_pkg::ST_IDLE;
         default: state_next = status_service_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg    <= status_service_pkg::ST_IDLE;
         cmd_ready    <= 1'b1;
         ovl_busy_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg    <= state_next;
         cmd_ready    <= (state_next == status_service_pkg::ST_IDLE);
         if (do_ovl) ovl_busy_reg <= 1'b1;
         else if (ovl_done) ovl_busy_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Measurement, trigger, self-test and settings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig_pulse <= 1'b0;
         cal_start  <= 1'b0;
         tst_result <= 1'b0;
         tst_valid  <= 1'b0;
         meas_start <= 1'b0;
         meas_abort <= 1'b0;
         auto_cal   <= 1'b0;
         cont_init  <= 1'b0;
         measuring_bit <= 1'b0;
         averaging_bit <= 1'b0;
         no_pending_operations_flag <= 1'b1;
         opc_pending <= 1'b0;
      end else if (clk_en) begin
         trig_pulse <= do_trg && trig_src_bus && waiting_trigger;
         cal_start  <= do_tst;
         tst_valid  <= (state_reg == status_service_pkg::ST_TEST) && cal_done;
         if ((state_reg == status_service_pkg::ST_TEST) && cal_done)
            tst_result <= !cal_pass;
         meas_abort <= do_abort;
         meas_start <= do_init || (do_abort && cont_init);
         if (do_cont) cont_init <= cmd_arg[0];
         if (do_init || (do_abort && cont_init)) measuring_bit <= 1'b1;
         else if (seq_done) measuring_bit <= 1'b0;
         if (do_abort) begin
            measuring_bit <= cont_init;
            averaging_bit <= 1'b0;
            no_pending_operations_flag <= 1'b0;
         end else if (ovl_done) no_pending_operations_flag <= 1'b1;
         if (do_ovl) opc_pending <= 1'b1;
         else if (ovl_done) opc_pending <= 1'b0;
         if (do_rst) begin
            opc_pending <= 1'b0;
            auto_cal    <= 1'b0;
            cont_init   <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Output registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_out <= 8'h00;
         psc_out  <= 1'b0;
         srq_out  <= 1'b0;
      end else if (clk_en) begin
         mask_out <= mask_next;
         psc_out  <= psc_reg;
         srq_out  <= srq_reg;
      end
   end
   always_comb stb_out = stb_reg;

   // ==========================================================
   // Assertions
   mask_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_sre |=> mask_reg == ($past(cmd_arg) & 8'hbf)) else $error("mask write lost");
   rst_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_rst && !do_sre && !do_pwr |=> $stable(mask_reg)) else $error("reset changed mask");
   rst_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_rst && !do_cont |=> !cont_init && !auto_cal && !opc_pending) else $error("reset bad");
   trig_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      trig_pulse |-> $past(trig_src_bus && waiting_trigger)) else $error("bad trigger");
   abort_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_abort |=> !averaging_bit && !no_pending_operations_flag) else $error("abort bits");
   srq_rise_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      srq_event |=> srq_reg) else $error("no service request");
   bit6_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      eff_mask[status_service_pkg::BIT_RQS] == 1'b0) else $error("bit 6 enabled");
   wait_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == status_service_pkg::ST_WAIT |-> !take) else $error("command during wait");

   // ==========================================================
   // Mask and retained storage checks
   mask_bit6_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_sre |=> !mask_reg[status_service_pkg::BIT_RQS])
      else $error("mask bit 6 stored");
   mask_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      mask_reg == 8'h00 |-> !srq_event)
      else $error("service request with empty mask");
   mask_pwr_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_pwr |=> mask_reg == ($past(psc_reg) ? status_service_pkg::MASK_RESET
                                            : $past(saved_mask_reg)))
      else $error("power-up mask wrong");
   psc_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_psc |=> psc_reg == ($past(cmd_arg) != 8'h00))
      else $error("clear flag write lost");
   saved_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_sre |=> saved_mask_reg == ($past(cmd_arg) & 8'hbf))
      else $error("saved mask write lost");
   rst_retain_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_rst |=> $stable(saved_mask_reg) && $stable(psc_reg))
      else $error("reset changed retained storage");
   mask_query_a: assert property (@(posedge clk) disable iff (sys_rst)
      mask_out == mask_reg)
      else $error("mask readback differs");

   // ==========================================================
   // Status byte checks
   cls_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_cls && !srq_event |=> !srq_reg)
      else $error("clear status kept request");
   srq_enable_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      (|rise_mask) |=> srq_reg)
      else $error("no request on enable rise");
   poll_rqs_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      serial_poll |=> stb_reg[status_service_pkg::BIT_RQS] == $past(srq_reg))
      else $error("poll bit 6 not request");
   query_mss_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      !serial_poll |=> stb_reg[status_service_pkg::BIT_RQS] == $past(mss))
      else $error("query bit 6 not summary");
   stb_sum_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      clk_en |=> {stb_reg[status_service_pkg::BIT_OPER], stb_reg[status_service_pkg::BIT_QUES],
                  stb_reg[status_service_pkg::BIT_DEV], stb_reg[status_service_pkg::BIT_USER]}
                 == $past({oper_summary, ques_summary, dev_summary, user_summary}))
      else $error("summary bits wrong");
   stb_mav_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      clk_en |=> stb_reg[status_service_pkg::BIT_MAV] == $past(outq_not_empty))
      else $error("message bit wrong");
   stb_esb_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      clk_en |=> stb_reg[status_service_pkg::BIT_ESB] == $past(esr_summary))
      else $error("event summary bit wrong");

   // ==========================================================
   // Command flow checks
   tst_res_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      tst_valid |-> tst_result == !$past(cal_pass))
      else $error("self-test result wrong");
   seq_block_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_seq |=> !cmd_ready)
      else $error("sequential command not blocking");
   ovl_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_ovl |=> cmd_ready)
      else $error("overlapped command blocking");
   abort_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_abort |=> meas_abort && (meas_start == $past(cont_init)))
      else $error("abort restart wrong");
   init_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_init |=> meas_start && measuring_bit)
      else $error("initiate did not start");
   abort_meas_a: assert property (@(posedge clk) disable iff (sys_rst)
      do_abort && !cont_init |=> !measuring_bit)
      else $error("abort kept measuring");

   cov_srq_c:   cover property (@(posedge clk) srq_event);
   cov_abort_c: cover property (@(posedge clk) do_abort && cont_init);
   cov_tst_c:   cover property (@(posedge clk) tst_valid && tst_result);
   cov_poll_c:  cover property (@(posedge clk) serial_poll && srq_reg);
   cov_wait_c:  cover property (@(posedge clk) state_reg == status_service_pkg::ST_WAIT && ovl_done);
endmodule : status_service_ctrl

// ### tb/bus_ctrl_model.sv
// Bus controller model that issues commands to the block
`timescale 1ns/1ps
module bus_ctrl_model (
   // Clock and handshake
   input  wire logic                clk,
   input  wire logic                cmd_ready,
   // Command request
   output logic                     cmd_valid,
   output status_service_pkg::cmd_t cmd_code,
   output logic [7:0]               cmd_arg
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = status_service_pkg::CMD_NONE;
      cmd_arg   = 8'h00;
   end
   // ==========================================================
   // Command issue, held until taken
   task automatic send(input status_service_pkg::cmd_t c, input logic [7:0] bits);
      logic [7:0] w;
      w = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (bits[i]) w = w + (8'h01 << i);
      end
      @(posedge clk) #1;
      cmd_valid = 1'b1;
      cmd_code  = c;
      cmd_arg   = w;
      while (cmd_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      cmd_code  = status_service_pkg::CMD_NONE;
      cmd_arg   = ~w;
   endtask : send
endmodule : bus_ctrl_model

// ### tb/tb_top.sv
// Self-checking testbench for the status and service request block
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // Signals
   logic clk, sys_rst, clk_en, cmd_valid, cmd_ready, srq_out, psc_out, trig_pulse, cal_start;
   logic tst_result, tst_valid, meas_start, meas_abort, auto_cal, cont_init;
   logic measuring_bit, averaging_bit, no_pending_operations_flag, opc_pending;
   logic user_summary, dev_summary, ques_summary, esr_summary, oper_summary;
   logic outq_not_empty, serial_poll, trig_src_bus, waiting_trigger;
   logic seq_done, ovl_done, cal_done, cal_pass;
   logic [7:0] cmd_arg, mask_out, stb_out;
   status_service_pkg::cmd_t cmd_code;
   int error_cnt, n_tests, cyc, k, n_trig, n_cal, n_tv, n_ms, n_ab;
   status_service_ctrl uut (.clk, .sys_rst, .clk_en, .cmd_valid, .cmd_code,
      .cmd_arg, .cmd_ready, .user_summary, .dev_summary, .ques_summary, .esr_summary,
      .oper_summary, .outq_not_empty, .serial_poll, .trig_src_bus, .waiting_trigger,
      .seq_done, .ovl_done, .cal_done, .cal_pass, .mask_out, .stb_out, .srq_out,
      .psc_out, .trig_pulse, .cal_start, .tst_result, .tst_valid, .meas_start,
      .meas_abort, .auto_cal, .cont_init, .measuring_bit, .averaging_bit,
      .no_pending_operations_flag, .opc_pending);
   bus_ctrl_model ctl (.clk, .cmd_ready, .cmd_valid, .cmd_code, .cmd_arg);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // Pulse counters and timeout
   always @(posedge clk) begin
      n_trig += (trig_pulse === 1'b1);
      n_cal  += (cal_start === 1'b1);
      n_tv   += (tst_valid === 1'b1);
      n_ms   += (meas_start === 1'b1);
      n_ab   += (meas_abort === 1'b1);
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   // ==========================================================
   // Main sequence
   initial begin
      {sys_rst, user_summary, dev_summary, ques_summary, esr_summary} = 5'h10;
      clk_en = 1'b1;
      {oper_summary, outq_not_empty, serial_poll, trig_src_bus} = 4'h0;
      {waiting_trigger, seq_done, ovl_done, cal_done, cal_pass} = 5'h0;
      tick(20);
      sys_rst = 1'b0;
      chk({cmd_ready, no_pending_operations_flag, opc_pending, mask_out[4:0]}, 8'hc0);
      {oper_summary, esr_summary, outq_not_empty, ques_summary, dev_summary} = 5'h1f;
      user_summary = 1'b1;
      tick(3);
      chk(stb_out, 8'hbd);
      clk_en = 1'b0;
      user_summary = 1'b0;
      tick(3);
      chk(stb_out, 8'hbd);
      clk_en = 1'b1;
      tick(3);
      chk(stb_out, 8'hbc);
      user_summary = 1'b1;
      chk({7'h0, srq_out}, 8'h00);
      ctl.send(status_service_pkg::CMD_SRE, 8'h01);
      tick(3);
      chk(mask_out, 8'h01);
      chk({srq_out, stb_out[6:0]}, 8'hfd);
      serial_poll = 1'b1;
      tick(1);
      chk(stb_out, 8'hfd);
      serial_poll = 1'b0;
      tick(3);
      chk({srq_out, stb_out[6:0]}, 8'h7d);
      serial_poll = 1'b1;
      tick(1);
      chk(stb_out, 8'hbd);
      serial_poll = 1'b0;
      {oper_summary, esr_summary, outq_not_empty, ques_summary, dev_summary} = 5'h00;
      user_summary = 1'b0;
      ctl.send(status_service_pkg::CMD_SRE, 8'h84);
      tick(3);
      chk({7'h0, srq_out}, 8'h00);
      dev_summary = 1'b1;
      tick(3);
      chk({7'h0, srq_out}, 8'h01);
      ctl.send(status_service_pkg::CMD_CLS, 8'h00);
      ctl.send(status_service_pkg::CMD_SRE, 8'hff);
      tick(3);
      chk(mask_out, 8'hbf);
      ctl.send(status_service_pkg::CMD_CLS, 8'h00);
      ctl.send(status_service_pkg::CMD_SRE, 8'h00);
      user_summary = 1'b1;
      tick(3);
      chk({srq_out, mask_out[6:0]}, 8'h00);
      ctl.send(status_service_pkg::CMD_CONT, 8'h01);
      ctl.send(status_service_pkg::CMD_PSC, 8'h00);
      ctl.send(status_service_pkg::CMD_SRE, 8'h21);
      ctl.send(status_service_pkg::CMD_OVL, 8'h00);
      chk({7'h0, opc_pending}, 8'h01);
      ctl.send(status_service_pkg::CMD_RST, 8'h00);
      tick(2);
      chk({3'h0, auto_cal, cont_init, psc_out, opc_pending, cmd_ready}, 8'h01);
      chk(mask_out, 8'h21);
      sys_rst = 1'b1;
      tick(1);
      sys_rst = 1'b0;
      ctl.send(status_service_pkg::CMD_POWERUP, 8'h00);
      tick(2);
      chk({psc_out, mask_out[6:0]}, 8'h21);
      ctl.send(status_service_pkg::CMD_PSC, 8'h80);
      ctl.send(status_service_pkg::CMD_POWERUP, 8'h00);
      tick(2);
      chk({psc_out, mask_out[6:0]}, 8'h80);
      for (int i = 0; i < 4; i++) begin
         {trig_src_bus, waiting_trigger} = 2'(i);
         k = n_trig;
         ctl.send(status_service_pkg::CMD_TRG, 8'h00);
         tick(2);
         chk(8'(n_trig - k), (i == 3) ? 8'h01 : 8'h00);
      end
      for (int p = 0; p < 2; p++) begin
         cal_pass = p[0];
         k = n_tv;
         ctl.send(status_service_pkg::CMD_TST, 8'h00);
         tick(3);
         chk({cmd_ready, 7'(n_cal)}, 8'(p + 1));
         cal_done = 1'b1;
         tick(1);
         cal_done = 1'b0;
         tick(3);
         chk({cmd_ready, tst_result, 6'(n_tv - k)}, {1'b1, ~p[0], 6'h01});
      end
      ctl.send(status_service_pkg::CMD_SEQ, 8'h00);
      tick(4);
      chk({7'h0, cmd_ready}, 8'h00);
      seq_done = 1'b1;
      tick(1);
      seq_done = 1'b0;
      ctl.send(status_service_pkg::CMD_OVL, 8'h00);
      tick(2);
      chk({7'h0, cmd_ready}, 8'h01);
      ctl.send(status_service_pkg::CMD_WAI, 8'h00);
      tick(5);
      chk({7'h0, cmd_ready}, 8'h00);
      ovl_done = 1'b1;
      tick(1);
      ovl_done = 1'b0;
      tick(2);
      chk({7'h0, cmd_ready}, 8'h01);
      ctl.send(status_service_pkg::CMD_CONT, 8'h01);
      k = n_ms;
      ctl.send(status_service_pkg::CMD_ABORT, 8'h00);
      tick(2);
      chk({4'(n_ms - k), 4'(n_ab)}, 8'h11);
      chk({5'h0, no_pending_operations_flag, measuring_bit, averaging_bit}, 8'h02);
      ctl.send(status_service_pkg::CMD_CONT, 8'h00);
      k = n_ms;
      ctl.send(status_service_pkg::CMD_ABORT, 8'h00);
      tick(2);
      chk({4'(n_ms - k), 4'(n_ab)}, 8'h02);
      chk({5'h0, no_pending_operations_flag, measuring_bit, averaging_bit}, 8'h00);
      ctl.send(status_service_pkg::CMD_INIT, 8'h00);
      tick(2);
      chk(8'(n_ms - k), 8'h01);
      test_done();
   end
endmodule : tb_top
